/* File: pkg/ubd_pkg.sv */
// Package with constants shared by the strap and descriptor control block.
package ubd_pkg;
  // ---------------------------------------------------------------
  // Clock source encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    UBD_CLK_XTAL12,
    UBD_CLK_EXT48,
    UBD_CLK_INVALID
  } ubd_clk_src_t;

  localparam int unsigned CLK_XTAL_MHZ = 12;
  localparam int unsigned CLK_EXT_MHZ  = 48;

  // ---------------------------------------------------------------
  // Interface and endpoint layout
  // ---------------------------------------------------------------
  localparam logic [1:0] ALT_PRINTER_UNI = 2'h0;
  localparam logic [1:0] ALT_PRINTER_BI  = 2'h1;
  localparam logic [1:0] ALT_VENDOR      = 2'h2;
  localparam logic [3:0] EP_CONTROL      = 4'h0;
  localparam logic [3:0] EP_BULK_OUT     = 4'h1;
  localparam logic [3:0] EP_BULK_IN      = 4'h2;

  // ---------------------------------------------------------------
  // Descriptor types and addressing
  // ---------------------------------------------------------------
  localparam logic [7:0]  DESC_TYPE_DEVICE = 8'h01;
  localparam logic [7:0]  DESC_TYPE_CONFIG = 8'h02;
  localparam logic [7:0]  DESC_TYPE_STRING = 8'h03;
  localparam logic [10:0] INT_ADDR_DEVICE  = 11'h000;
  localparam logic [10:0] INT_ADDR_CONFIG  = 11'h012;
  localparam logic [10:0] STR0_ADDR        = 11'h000;
  localparam int unsigned STR_ADDR_SHIFT   = 2;
  localparam int unsigned ROM_DEPTH        = 128;
  localparam logic [7:0]  STR0_LENGTH      = 8'h04;
  localparam logic [15:0] LANGID_DEFAULT   = 16'h0409;

  // ---------------------------------------------------------------
  // Configuration attribute bits
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_ATTR_BUS  = 8'h80;
  localparam logic [7:0] CFG_ATTR_SELF = 8'h40;
endpackage

/* File: rtl/ubd_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/100ps
module ubd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule

/* File: rtl/ubd_ep_map.sv */
// Endpoint availability per alternate setting.
`timescale 1ns/100ps
module ubd_ep_map (
  input  wire logic [1:0] alt_i,
  input  wire logic [3:0] ep_i,
  output logic            ep_valid_o,
  output logic            is_in_o
);
  logic ctl_hit;
  logic out_hit;
  logic in_hit;
  logic alt_ok;

  // Control endpoint is present in every setting.
  assign ctl_hit = (ep_i == ubd_pkg::EP_CONTROL);
  // Bulk OUT is present in every setting.
  assign out_hit = (ep_i == ubd_pkg::EP_BULK_OUT);
  // Bulk IN only exists in the bidirectional and vendor settings.
  assign in_hit  = (ep_i == ubd_pkg::EP_BULK_IN) &&
                   ((alt_i == ubd_pkg::ALT_PRINTER_BI) || (alt_i == ubd_pkg::ALT_VENDOR));
  assign alt_ok  = (alt_i <= ubd_pkg::ALT_VENDOR);
  assign ep_valid_o = alt_ok && (ctl_hit || out_hit || in_hit);
  assign is_in_o    = in_hit;
endmodule

/* File: rtl/ubd_ctrl.sv */
// Strap handling, indicators, endpoint map and descriptor address control.
`timescale 1ns/100ps
module ubd_ctrl (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        chip_reset_i,
  input  wire logic        clock_select_hi_strap_i,
  input  wire logic        clock_select_lo_strap_i,
  input  wire logic        output_tristate_strap_i,
  input  wire logic        wide_bus_strap_i,
  input  wire logic        self_powered_i,
  input  wire logic        usb_bus_reset_i,
  input  wire logic        usb_suspend_i,
  input  wire logic        port_acknowledge_n_i,
  input  wire logic        ext_desc_present_i,
  input  wire logic [1:0]  alt_setting_i,
  input  wire logic [3:0]  ep_num_i,
  input  wire logic        desc_req_i,
  input  wire logic [7:0]  desc_type_i,
  input  wire logic [7:0]  desc_index_i,
  input  wire logic [10:0] ext_std_addr_i,
  input  wire logic        port_strobe_req_i,
  input  wire logic        port_autofeed_req_i,
  input  wire logic        ata_write_req_i,
  input  wire logic        ata_read_req_i,
  input  wire logic [7:0]  low_data_byte_out_i,
  input  wire logic [7:0]  high_data_byte_out_i,
  input  wire logic        data_drive_i,
  input  wire logic        host_logic_high_req_i,
  input  wire logic        ata_chip_select_a_req_i,
  input  wire logic        ata_chip_select_b_req_i,
  input  wire logic [2:0]  ata_address_req_i,
  output logic [1:0]       clk_src_o,
  output logic             clk_src_err_o,
  output logic             wide_mode_o,
  output logic [7:0]       cfg_attributes_o,
  output logic             bus_reset_indicator_n_o,
  output logic             suspend_o,
  output logic             ep_valid_o,
  output logic             ep_is_in_o,
  output logic             ata_iordy_o,
  output logic             desc_ack_o,
  output logic             desc_ext_o,
  output logic [10:0]      desc_addr_o,
  output logic [7:0]       desc_byte0_o,
  output logic [7:0]       low_data_byte_o,
  output logic [7:0]       low_data_byte_oe_n_o,
  output logic [7:0]       high_data_byte_o,
  output logic [7:0]       high_data_byte_oe_n_o,
  output logic             host_logic_high_out_o,
  output logic             host_logic_high_out_oe_n_o,
  output logic             port_strobe_n_o,
  output logic             port_autofeed_n_o,
  output logic             port_ctrl_oe_n_o,
  output logic             ata_chip_select_a_o,
  output logic             ata_chip_select_b_o,
  output logic [2:0]       ata_address_lines_o,
  output logic             ata_oe_n_o
);
  // ---------------------------------------------------------------
  // Reset and input synchronisers
  // ---------------------------------------------------------------
  // The pin reset passes a two-flop sync on both edges and is applied as a synchronous reset,
  // so a glitch cannot leave half the flops reset.
  logic rst_meta_reg;
  logic rst_n_reg;
  logic [8:0] pins_async;
  logic [8:0] pins_sync;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= ~chip_reset_i;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  assign pins_async = {clock_select_hi_strap_i, clock_select_lo_strap_i, output_tristate_strap_i,
                       wide_bus_strap_i, self_powered_i, usb_bus_reset_i, usb_suspend_i,
                       port_acknowledge_n_i, ext_desc_present_i};

  ubd_sync #(
    .W(9)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (pins_async),
    .q_o      (pins_sync)
  );

  logic cs_hi;
  logic cs_lo;
  logic tri_s;
  logic wide_s;
  logic selfp_s;
  logic busrst_s;
  logic susp_s;
  logic ack_n_s;
  logic extp_s;

  assign {cs_hi, cs_lo, tri_s, wide_s, selfp_s, busrst_s, susp_s, ack_n_s, extp_s} = pins_sync;

  // ---------------------------------------------------------------
  // Strap decode
  // ---------------------------------------------------------------
  ubd_pkg::ubd_clk_src_t clk_src_next;
  logic                  tri_ok;
  logic                  tri_next;

  assign clk_src_next = (!cs_hi && !cs_lo) ? ubd_pkg::UBD_CLK_XTAL12 :
                        ( cs_hi &&  cs_lo) ? ubd_pkg::UBD_CLK_EXT48 : ubd_pkg::UBD_CLK_INVALID;
  // Output disable is honoured only in the crystal configuration the board may use it in.
  assign tri_ok   = (clk_src_next == ubd_pkg::UBD_CLK_XTAL12);
  assign tri_next = tri_s && tri_ok;

  logic [1:0] clk_src_reg;
  logic       clk_err_reg;
  logic       tri_reg;
  logic       wide_reg;
  logic [7:0] attr_reg;
  logic [7:0] attr_next;

  assign attr_next = selfp_s ? (ubd_pkg::CFG_ATTR_BUS | ubd_pkg::CFG_ATTR_SELF)
                             : ubd_pkg::CFG_ATTR_BUS;

  // Straps are tracked continuously; they are meant to be static, so this costs nothing.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_src_reg <= 2'h0;
      clk_err_reg <= 1'b0;
      tri_reg     <= 1'b1;
      wide_reg    <= 1'b0;
      attr_reg    <= ubd_pkg::CFG_ATTR_BUS;
    end else if (!rst_n_reg) begin
      clk_src_reg <= 2'h0;
      clk_err_reg <= 1'b0;
      tri_reg     <= 1'b1;
      wide_reg    <= 1'b0;
      attr_reg    <= ubd_pkg::CFG_ATTR_BUS;
    end else begin
      clk_src_reg <= clk_src_next;
      clk_err_reg <= (clk_src_next == ubd_pkg::UBD_CLK_INVALID);
      tri_reg     <= tri_next;
      wide_reg    <= wide_s;
      attr_reg    <= attr_next;
    end
  end

  // ---------------------------------------------------------------
  // Bus indicators and endpoint map
  // ---------------------------------------------------------------
  logic busrst_n_reg;
  logic susp_reg;
  logic ep_valid_reg;
  logic ep_in_reg;
  logic iordy_reg;
  logic ep_valid_w;
  logic ep_in_w;

  ubd_ep_map u_ep_map (
    .alt_i     (alt_setting_i),
    .ep_i      (ep_num_i),
    .ep_valid_o(ep_valid_w),
    .is_in_o   (ep_in_w)
  );

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busrst_n_reg <= 1'b1;
      susp_reg     <= 1'b0;
      ep_valid_reg <= 1'b0;
      ep_in_reg    <= 1'b0;
      iordy_reg    <= 1'b0;
    end else if (!rst_n_reg) begin
      busrst_n_reg <= 1'b1;
      susp_reg     <= 1'b0;
      ep_valid_reg <= 1'b0;
      ep_in_reg    <= 1'b0;
      iordy_reg    <= 1'b0;
    end else begin
      busrst_n_reg <= ~busrst_s;
      susp_reg     <= susp_s;
      ep_valid_reg <= ep_valid_w;
      ep_in_reg    <= ep_in_w;
      iordy_reg    <= wide_reg & ack_n_s;
    end
  end

  // ---------------------------------------------------------------
  // Descriptor address sequencing
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    UBD_D_IDLE,
    UBD_D_ANSWER
  } ubd_dstate_t;

  function automatic logic [10:0] ubd_str_addr(input logic [7:0] idx);
    ubd_str_addr = {1'b0, idx, 2'b00};
  endfunction

  ubd_dstate_t dstate_reg;
  ubd_dstate_t dstate_next;
  logic        is_str;
  logic        is_std;
  logic        use_ext;
  logic [10:0] addr_next;
  logic [7:0]  byte0_next;
  logic        dext_reg;
  logic [10:0] daddr_reg;
  logic [7:0]  dbyte0_reg;
  logic        dack_reg;

  assign is_str  = (desc_type_i == ubd_pkg::DESC_TYPE_STRING);
  assign is_std  = (desc_type_i == ubd_pkg::DESC_TYPE_DEVICE) || (desc_type_i == ubd_pkg::DESC_TYPE_CONFIG);
  // Strings only exist externally; standard descriptors fall back to the on-chip table.
  assign use_ext = is_str | extp_s;
  assign addr_next = is_str ? ((desc_index_i == 8'h00) ? ubd_pkg::STR0_ADDR
                                                       : ubd_str_addr(desc_index_i))
                   : extp_s ? ext_std_addr_i
                   : (desc_type_i == ubd_pkg::DESC_TYPE_CONFIG) ? ubd_pkg::INT_ADDR_CONFIG
                   : ubd_pkg::INT_ADDR_DEVICE;
  // Index 0 always carries a single language code, so its length is fixed.
  assign byte0_next = (is_str && desc_index_i == 8'h00) ? ubd_pkg::STR0_LENGTH : 8'h00;

  always_comb begin
    dstate_next = dstate_reg;
    case (dstate_reg)
      UBD_D_IDLE: begin
        if (desc_req_i && (is_str || is_std)) begin
          dstate_next = UBD_D_ANSWER;
        end
      end
      UBD_D_ANSWER: begin
        dstate_next = UBD_D_IDLE;
      end
      default: begin
        dstate_next = UBD_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dstate_reg <= UBD_D_IDLE;
      dack_reg   <= 1'b0;
      dext_reg   <= 1'b0;
      daddr_reg  <= 11'h000;
      dbyte0_reg <= 8'h00;
    end else if (!rst_n_reg) begin
      dstate_reg <= UBD_D_IDLE;
      dack_reg   <= 1'b0;
      dext_reg   <= 1'b0;
      daddr_reg  <= 11'h000;
      dbyte0_reg <= 8'h00;
    end else begin
      dstate_reg <= dstate_next;
      dack_reg   <= (dstate_reg == UBD_D_IDLE) && (dstate_next == UBD_D_ANSWER);
      if ((dstate_reg == UBD_D_IDLE) && (dstate_next == UBD_D_ANSWER)) begin
        dext_reg   <= use_ext;
        daddr_reg  <= addr_next;
        dbyte0_reg <= byte0_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // Parallel and ATA pin drivers
  // ---------------------------------------------------------------
  logic [7:0] lo_reg;
  logic [7:0] lo_oe_n_reg;
  logic [7:0] hi_reg;
  logic [7:0] hi_oe_n_reg;
  logic       hlh_reg;
  logic       stb_n_reg;
  logic       afd_n_reg;
  logic       cs_a_reg;
  logic       cs_b_reg;
  logic [2:0] da_reg;
  logic       stb_n_next;
  logic       afd_n_next;
  logic       hi_en;

  assign stb_n_next = wide_reg ? ~ata_write_req_i : ~port_strobe_req_i;
  assign afd_n_next = wide_reg ? ~ata_read_req_i : ~port_autofeed_req_i;
  assign hi_en      = wide_reg && data_drive_i && !tri_reg;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_reg      <= 8'h00;
      lo_oe_n_reg <= 8'hFF;
      hi_reg      <= 8'h00;
      hi_oe_n_reg <= 8'hFF;
      hlh_reg     <= 1'b0;
      stb_n_reg   <= 1'b1;
      afd_n_reg   <= 1'b1;
      cs_a_reg    <= 1'b1;
      cs_b_reg    <= 1'b1;
      da_reg      <= 3'h0;
    end else if (!rst_n_reg) begin
      lo_oe_n_reg <= 8'hFF;
      hi_oe_n_reg <= 8'hFF;
      stb_n_reg   <= 1'b1;
      afd_n_reg   <= 1'b1;
      cs_a_reg    <= 1'b1;
      cs_b_reg    <= 1'b1;
    end else begin
      lo_reg      <= low_data_byte_out_i;
      lo_oe_n_reg <= {8{~(data_drive_i && !tri_reg)}};
      hi_reg      <= high_data_byte_out_i;
      hi_oe_n_reg <= {8{~hi_en}};
      hlh_reg     <= host_logic_high_req_i;
      stb_n_reg   <= stb_n_next;
      afd_n_reg   <= afd_n_next;
      cs_a_reg    <= ~(wide_reg && ata_chip_select_a_req_i);
      cs_b_reg    <= ~(wide_reg && ata_chip_select_b_req_i);
      da_reg      <= wide_reg ? ata_address_req_i : 3'h0;
    end
  end

  assign clk_src_o                  = clk_src_reg;
  assign clk_src_err_o              = clk_err_reg;
  assign wide_mode_o                = wide_reg;
  assign cfg_attributes_o           = attr_reg;
  assign bus_reset_indicator_n_o    = busrst_n_reg;
  assign suspend_o                  = susp_reg;
  assign ep_valid_o                 = ep_valid_reg;
  assign ep_is_in_o                 = ep_in_reg;
  assign ata_iordy_o                = iordy_reg;
  assign desc_ack_o                 = dack_reg;
  assign desc_ext_o                 = dext_reg;
  assign desc_addr_o                = daddr_reg;
  assign desc_byte0_o               = dbyte0_reg;
  assign low_data_byte_o            = lo_reg;
  assign low_data_byte_oe_n_o       = lo_oe_n_reg;
  assign high_data_byte_o           = hi_reg;
  assign high_data_byte_oe_n_o      = hi_oe_n_reg;
  assign host_logic_high_out_o      = hlh_reg;
  assign host_logic_high_out_oe_n_o = tri_reg;
  assign port_strobe_n_o            = stb_n_reg;
  assign port_autofeed_n_o          = afd_n_reg;
  assign port_ctrl_oe_n_o           = tri_reg;
  assign ata_chip_select_a_o        = cs_a_reg;
  assign ata_chip_select_b_o        = cs_b_reg;
  assign ata_address_lines_o        = da_reg;
  assign ata_oe_n_o                 = tri_reg;
endmodule

/* File: dv/ubd_ctrl_properties.sv */
// Checker with the timing and mapping properties of the strap, indicator and descriptor block.
`timescale 1ns/100ps
module ubd_ctrl_chk (
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  input wire logic        chip_reset_i,
  input wire logic        clock_select_hi_strap_i,
  input wire logic        clock_select_lo_strap_i,
  input wire logic        output_tristate_strap_i,
  input wire logic        wide_bus_strap_i,
  input wire logic        self_powered_i,
  input wire logic        usb_bus_reset_i,
  input wire logic        usb_suspend_i,
  input wire logic [1:0]  alt_setting_i,
  input wire logic [3:0]  ep_num_i,
  input wire logic        desc_req_i,
  input wire logic [7:0]  desc_type_i,
  input wire logic [7:0]  desc_index_i,
  input wire logic        port_strobe_req_i,
  input wire logic        ata_write_req_i,
  input wire logic [1:0]  clk_src_o,
  input wire logic [7:0]  cfg_attributes_o,
  input wire logic        bus_reset_indicator_n_o,
  input wire logic        suspend_o,
  input wire logic        ep_valid_o,
  input wire logic        desc_ack_o,
  input wire logic        desc_ext_o,
  input wire logic [10:0] desc_addr_o,
  input wire logic [7:0]  desc_byte0_o,
  input wire logic [7:0]  low_data_byte_oe_n_o,
  input wire logic        port_ctrl_oe_n_o,
  input wire logic        ata_oe_n_o,
  input wire logic        port_strobe_n_o
);
  // Chip reset passes a synchroniser, so outputs are trusted only once it has stayed low a while.
  logic [2:0] quiet_reg;
  logic       ep_exp;
  logic       take;
  logic       type_ok;
  assign ep_exp = (alt_setting_i != 2'h3) && (ep_num_i < 4'h2 || (ep_num_i == 4'h2 && alt_setting_i != 2'h0));
  assign type_ok = desc_type_i inside {ubd_pkg::DESC_TYPE_DEVICE, ubd_pkg::DESC_TYPE_CONFIG, ubd_pkg::DESC_TYPE_STRING};
  assign take = (quiet_reg == 3'h7) && desc_req_i && !desc_ack_o;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) quiet_reg <= 3'h0;
    else if (chip_reset_i) quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_xtal_clock_sel: assert property ((!chip_reset_i && !clock_select_hi_strap_i && !clock_select_lo_strap_i)[*8]
    |-> clk_src_o == ubd_pkg::UBD_CLK_XTAL12) else $error("clock source not crystal");
  a_ext_clock_sel: assert property ((!chip_reset_i && clock_select_hi_strap_i && clock_select_lo_strap_i)[*8]
    |-> clk_src_o == ubd_pkg::UBD_CLK_EXT48) else $error("clock source not external input");
  a_outputs_tristate: assert property ((!chip_reset_i && output_tristate_strap_i && !clock_select_hi_strap_i
    && !clock_select_lo_strap_i)[*8] |-> ata_oe_n_o && port_ctrl_oe_n_o && low_data_byte_oe_n_o == 8'hFF)
    else $error("outputs driven while disabled");
  a_power_attr: assert property ((!chip_reset_i && $stable(self_powered_i))[*8]
    |-> cfg_attributes_o == (self_powered_i ? 8'hC0 : ubd_pkg::CFG_ATTR_BUS)) else $error("power attribute wrong");
  a_bus_reset_ind: assert property ((!chip_reset_i && $stable(usb_bus_reset_i))[*8]
    |-> bus_reset_indicator_n_o == !usb_bus_reset_i) else $error("bus reset indicator wrong");
  a_suspend_ind: assert property ((!chip_reset_i && $stable(usb_suspend_i))[*8]
    |-> suspend_o == usb_suspend_i) else $error("suspend indicator wrong");
  a_chip_reset_hold: assert property (chip_reset_i[*4]
    |-> ata_oe_n_o && bus_reset_indicator_n_o && !desc_ack_o) else $error("chip reset not applied");
  a_desc_ack_pulse: assert property (take && type_ok |=> desc_ack_o ##1 !desc_ack_o)
    else $error("descriptor ack not one cycle");
  a_desc_refused: assert property (take && !type_ok |=> !desc_ack_o) else $error("bad type acknowledged");
  a_string_addr: assert property (take && desc_type_i == ubd_pkg::DESC_TYPE_STRING |=> desc_ext_o
    && desc_addr_o == {1'b0, $past(desc_index_i), 2'h0}
    && desc_byte0_o == (($past(desc_index_i) == 8'h00) ? ubd_pkg::STR0_LENGTH : 8'h00)) else $error("string address");
  a_ep_map_valid: assert property (quiet_reg == 3'h7 |=> ep_valid_o == $past(ep_exp))
    else $error("endpoint map wrong");
  a_strobe_select: assert property ((!chip_reset_i && $stable(wide_bus_strap_i))[*8] |=> port_strobe_n_o
    == !$past(wide_bus_strap_i ? ata_write_req_i : port_strobe_req_i)) else $error("strobe source wrong");
  c_desc: cover property (take && desc_type_i == ubd_pkg::DESC_TYPE_STRING);
  c_bus_reset: cover property (!bus_reset_indicator_n_o);
  c_suspend: cover property (suspend_o);
endmodule

bind ubd_ctrl ubd_ctrl_chk u_chk (.*);

/* File: dv/ubd_host_model.sv */
// Behavioural model of the upstream host as seen through the bus reset and suspend pins.
`timescale 1ns/100ps
module ubd_host_model #(
  parameter int unsigned RST_CYC  = 8,
  parameter int unsigned IDLE_CYC = 12
) (
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  input  wire logic bus_reset_cmd_i,
  input  wire logic traffic_i,
  output logic      usb_bus_reset_o,
  output logic      usb_suspend_o
);
  logic [7:0] rst_reg;
  logic [7:0] idle_reg;
  // A commanded bus reset lasts a fixed span, as a host would hold it.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_reg <= 8'h00;
    else if (bus_reset_cmd_i) rst_reg <= 8'(RST_CYC);
    else if (rst_reg != 8'h00) rst_reg <= rst_reg - 8'h01;
  end
  // Idle time is short here; a real bus needs milliseconds, which would only lengthen the run.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) idle_reg <= 8'h00;
    else if (traffic_i || rst_reg != 8'h00) idle_reg <= 8'h00;
    else if (idle_reg != 8'(IDLE_CYC)) idle_reg <= idle_reg + 8'h01;
  end
  assign usb_bus_reset_o = rst_reg != 8'h00;
  assign usb_suspend_o   = idle_reg == 8'(IDLE_CYC);
endmodule

/* File: dv/testbench.sv */
// Self-checking testbench for the strap, indicator, endpoint and descriptor control block.
`timescale 1ns/100ps
module testbench;
  logic        ref_clk_i, arst_n_i, chip_reset_i, clock_select_hi_strap_i, clock_select_lo_strap_i;
  logic        output_tristate_strap_i, wide_bus_strap_i, self_powered_i, port_acknowledge_n_i, ext_desc_present_i;
  logic        desc_req_i, port_strobe_req_i, port_autofeed_req_i, ata_write_req_i, ata_read_req_i, data_drive_i;
  logic        host_logic_high_req_i, ata_chip_select_a_req_i, ata_chip_select_b_req_i;
  logic        bus_reset_cmd, traffic, usb_bus_reset_i, usb_suspend_i;
  logic [1:0]  alt_setting_i, clk_src_o;
  logic [2:0]  ata_address_req_i, ata_address_lines_o;
  logic [7:0]  low_data_byte_o, high_data_byte_o;
  logic        host_logic_high_out_o, ata_chip_select_a_o, ata_chip_select_b_o;
  logic [3:0]  ep_num_i;
  logic [7:0]  desc_type_i, desc_index_i, low_data_byte_out_i, high_data_byte_out_i, cfg_attributes_o;
  logic [7:0]  desc_byte0_o, low_data_byte_oe_n_o, high_data_byte_oe_n_o;
  logic [10:0] ext_std_addr_i, desc_addr_o;
  logic        clk_src_err_o, wide_mode_o, bus_reset_indicator_n_o, suspend_o, ep_valid_o, ep_is_in_o, ata_iordy_o;
  logic        desc_ack_o, desc_ext_o, host_logic_high_out_oe_n_o, port_strobe_n_o, port_autofeed_n_o;
  logic        port_ctrl_oe_n_o, ata_oe_n_o;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  ubd_ctrl uut (.*);
  ubd_host_model u_host (.ref_clk_i, .arst_n_i, .bus_reset_cmd_i(bus_reset_cmd), .traffic_i(traffic),
    .usb_bus_reset_o(usb_bus_reset_i), .usb_suspend_o(usb_suspend_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // The whole run takes under two hundred cycles, so this ceiling only trips on a hang.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Straps cross a synchroniser, so each change is given eight cycles before outputs are judged.
  task automatic straps(input logic [4:0] s);
    @(posedge ref_clk_i);
    {clock_select_hi_strap_i, clock_select_lo_strap_i, output_tristate_strap_i, wide_bus_strap_i, self_powered_i} <= s;
    settle(8);
  endtask
  task automatic t_clock;
    straps(5'b00001);
    chk(clk_src_o, ubd_pkg::UBD_CLK_XTAL12);
    chk(cfg_attributes_o, 8'hC0);
    straps(5'b11000);
    chk(clk_src_o, ubd_pkg::UBD_CLK_EXT48);
    chk(cfg_attributes_o, ubd_pkg::CFG_ATTR_BUS);
    straps(5'b01000);
    chk(clk_src_err_o, 1'b1);
  endtask
  task automatic t_tristate;
    straps(5'b00110);
    chk(low_data_byte_oe_n_o, 8'hFF);
    chk(high_data_byte_oe_n_o, 8'hFF);
    chk(host_logic_high_out_oe_n_o, 1'b1);
    chk(port_ctrl_oe_n_o, 1'b1);
    chk(ata_oe_n_o, 1'b1);
    straps(5'b11110);
    chk(low_data_byte_oe_n_o, 8'h00);
    chk(ata_oe_n_o, 1'b0);
  endtask
  task automatic t_wide(input logic w);
    straps({3'b000, w, 1'b0});
    chk(wide_mode_o, w);
    chk(high_data_byte_oe_n_o, {8{!w}});
    chk(ata_oe_n_o, 1'b0);
    chk(ata_chip_select_a_o, !w);
    chk(ata_chip_select_b_o, 1'b1);
    chk(ata_address_lines_o, w ? 3'h5 : 3'h0);
    chk(high_data_byte_o, 8'h5A);
    chk(low_data_byte_o, 8'hA5);
    chk(host_logic_high_out_o, 1'b1);
    chk(port_strobe_n_o, w);
    chk(port_autofeed_n_o, !w);
    chk(ata_iordy_o, w);
  endtask
  task automatic t_indicators;
    @(posedge ref_clk_i);
    bus_reset_cmd <= 1'b1;
    @(posedge ref_clk_i);
    bus_reset_cmd <= 1'b0;
    settle(5);
    chk(bus_reset_indicator_n_o, 1'b0);
    settle(12);
    chk(bus_reset_indicator_n_o, 1'b1);
    traffic <= 1'b0;
    settle(20);
    chk(suspend_o, 1'b1);
    traffic <= 1'b1;
    settle(6);
    chk(suspend_o, 1'b0);
  endtask
  task automatic t_ep;
    logic exp;
    for (int a = 0; a < 4; a++) begin
      for (int e = 0; e < 4; e++) begin
        @(posedge ref_clk_i);
        alt_setting_i <= 2'(a);
        ep_num_i <= 4'(e);
        settle(1);
        exp = (a != 3) && (e < 2 || (e == 2 && a != 0));
        chk(ep_valid_o, exp);
        if (e != 0) chk(ep_is_in_o, exp && e == 2);
      end
    end
  endtask
  task automatic desc(input logic [7:0] ty, input logic [7:0] ix, input logic ack, input logic [10:0] addr,
                      input logic ext);
    @(posedge ref_clk_i);
    desc_req_i <= 1'b1;
    desc_type_i <= ty;
    desc_index_i <= ix;
    @(posedge ref_clk_i);
    desc_req_i <= 1'b0;
    #1;
    chk(desc_ack_o, ack);
    if (ack) begin
      chk(desc_addr_o, addr);
      chk(desc_ext_o, ext);
    end
  endtask
  task automatic t_desc;
    desc(ubd_pkg::DESC_TYPE_DEVICE, 8'h00, 1'b1, ubd_pkg::INT_ADDR_DEVICE, 1'b0);
    desc(ubd_pkg::DESC_TYPE_CONFIG, 8'h00, 1'b1, ubd_pkg::INT_ADDR_CONFIG, 1'b0);
    desc(8'h04, 8'h00, 1'b0, 11'h000, 1'b0);
    desc(ubd_pkg::DESC_TYPE_STRING, 8'h00, 1'b1, ubd_pkg::STR0_ADDR, 1'b1);
    chk(desc_byte0_o, ubd_pkg::STR0_LENGTH);
    desc(ubd_pkg::DESC_TYPE_STRING, 8'h1A, 1'b1, 11'h068, 1'b1);
    desc(ubd_pkg::DESC_TYPE_STRING, 8'hFF, 1'b1, 11'h3FC, 1'b1);
    @(posedge ref_clk_i);
    ext_desc_present_i <= 1'b1;
    settle(8);
    desc(ubd_pkg::DESC_TYPE_DEVICE, 8'h00, 1'b1, 11'h155, 1'b1);
    desc(ubd_pkg::DESC_TYPE_CONFIG, 8'h00, 1'b1, 11'h155, 1'b1);
  endtask
  task automatic t_chip_reset;
    straps(5'b00011);
    @(posedge ref_clk_i);
    chip_reset_i <= 1'b1;
    settle(6);
    chk(ata_oe_n_o, 1'b1);
    chk(low_data_byte_oe_n_o, 8'hFF);
    chk(bus_reset_indicator_n_o, 1'b1);
    chk(cfg_attributes_o, ubd_pkg::CFG_ATTR_BUS);
    chip_reset_i <= 1'b0;
    settle(8);
    chk(ata_oe_n_o, 1'b0);
    chk(cfg_attributes_o, 8'hC0);
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    arst_n_i = 1'b0;
    {chip_reset_i, clock_select_hi_strap_i, clock_select_lo_strap_i, output_tristate_strap_i, wide_bus_strap_i,
     self_powered_i, ext_desc_present_i, desc_req_i, port_autofeed_req_i, ata_write_req_i, bus_reset_cmd} = '0;
    {port_strobe_req_i, ata_read_req_i, port_acknowledge_n_i, data_drive_i, host_logic_high_req_i, traffic} = '1;
    ata_chip_select_a_req_i = 1'b1;
    {ata_chip_select_b_req_i, alt_setting_i, ep_num_i, desc_type_i, desc_index_i} = '0;
    {low_data_byte_out_i, high_data_byte_out_i} = 16'hA55A;
    ata_address_req_i = 3'h5;
    ext_std_addr_i = 11'h155;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_clock();
    t_tristate();
    t_wide(1'b0);
    t_wide(1'b1);
    t_indicators();
    t_ep();
    t_desc();
    t_chip_reset();
    final_report();
  end
endmodule
